// >>> verilog/bglbp_pkg.sv
// Package for the board GPIO block: register map, field layout, reset values.
// Assumes a 32-bit APB register bus and two banks of eight pins.
package bglbp_pkg;

   // Widths
   localparam int unsigned ADDR_W     = 12;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned BANK_PINS  = 8;
   localparam int unsigned NUM_BANKS  = 2;
   localparam int unsigned NUM_PINS   = 16;

   // Register byte offsets
   localparam logic [11:0] OFS_BANK_A = 12'h000;
   localparam logic [11:0] OFS_BANK_C = 12'h004;

   // Field positions (low bit of each byte-wide field)
   localparam int unsigned FLD_MODE_LSB = 24;
   localparam int unsigned FLD_DIR_LSB  = 16;
   localparam int unsigned FLD_ALT_LSB  = 8;
   localparam int unsigned FLD_DATA_LSB = 0;

   // Byte lane of each field within the word
   localparam int unsigned LANE_MODE = 3;
   localparam int unsigned LANE_DIR  = 2;
   localparam int unsigned LANE_ALT  = 1;
   localparam int unsigned LANE_DATA = 0;

   // Board pins inside bank C
   localparam int unsigned PIN_LED    = 6;
   localparam int unsigned PIN_BUTTON = 5;

   // Reset values, bank A
   localparam logic [7:0] RST_A_MODE = 8'h00;
   localparam logic [7:0] RST_A_DIR  = 8'h00;
   localparam logic [7:0] RST_A_ALT  = 8'h00;
   localparam logic [7:0] RST_A_DATA = 8'h00;

   // Reset values, bank C: indicator pin is an output driven high
   localparam logic [7:0] RST_C_MODE = 8'h00;
   localparam logic [7:0] RST_C_DIR  = 8'h40;
   localparam logic [7:0] RST_C_ALT  = 8'h00;
   localparam logic [7:0] RST_C_DATA = 8'h40;

   // Which banks carry an alternate-function field
   localparam logic [1:0] BANK_HAS_ALT = 2'h2;

endpackage

// >>> verilog/bglbp_pin_cell.sv
// One GPIO pin: input synchroniser and registered output driver.
// Assumes the pin input is asynchronous to CLK.
`timescale 1ns/1ns
`default_nettype none

module bglbp_pin_cell (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin_in,
   input  wire logic drive_val,
   input  wire logic drive_en,
   output var  logic level,
   output var  logic pin_out,
   output var  logic pin_oe
);

   logic meta_reg;
   logic sync_reg;

   // Two-flop synchroniser; only the second stage is read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign level = sync_reg;

   // Registered drive so the pin never glitches from decode logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_out <= drive_val;
         pin_oe  <= drive_en;
      end
   end

endmodule

`default_nettype wire

// >>> verilog/bglbp_top.sv
// Board GPIO port: two banks of eight pins behind an APB slave.
// Assumes an APB master on CLK and pins asynchronous to CLK.
//
// How it works
// - Sixteen pins, two registers, eight each.
// - Per pin: mode, direction, data; alt only C.
// - Data reads pin level; writes set output.
// - Bank C pin 6 outputs; high lights indicator.
// - Bank C pin 5 input; low when pressed.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module bglbp_top
   import bglbp_pkg::*;
(
   input  wire logic                      CLK,
   input  wire logic                      RST,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [bglbp_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [bglbp_pkg::DATA_W-1:0] PWDATA,
   input  wire logic [3:0]                PSTRB,
   output var  logic [bglbp_pkg::DATA_W-1:0] PRDATA,
   output var  logic                      PREADY,
   output var  logic                      PSLVERR,
   input  wire logic [7:0]                GPIO_A_IN,
   output var  logic [7:0]                GPIO_A_OUT,
   output var  logic [7:0]                GPIO_A_OE,
   input  wire logic [7:0]                GPIO_C_IN,
   output var  logic [7:0]                GPIO_C_OUT,
   output var  logic [7:0]                GPIO_C_OE,
   output var  logic                      INDICATOR_LIT,
   output var  logic                      BUTTON_PRESSED
);
   import bglbp_pkg::*;

   // Per-bank configuration storage
   logic [7:0]          pin_function_select_reg [NUM_BANKS];
   logic [7:0]          pin_direction_reg       [NUM_BANKS];
   logic [7:0]          pin_alt_function_reg    [NUM_BANKS];
   logic [7:0]          data_reg                [NUM_BANKS];
   logic [7:0]          pin_function_select_next[NUM_BANKS];
   logic [7:0]          pin_direction_next      [NUM_BANKS];
   logic [7:0]          pin_alt_function_next   [NUM_BANKS];
   logic [7:0]          data_next               [NUM_BANKS];

   // Pin-side vectors, bank A in the low byte
   logic [NUM_PINS-1:0] pin_in_all;
   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] pin_drive_val;
   logic [NUM_PINS-1:0] pin_drive_en;
   logic [NUM_PINS-1:0] pin_out_all;
   logic [NUM_PINS-1:0] pin_oe_all;

   // Bus handshake state and board flag flops
   logic                prdata_reg_unused;
   logic [DATA_W-1:0]   prdata_reg;
   logic [DATA_W-1:0]   prdata_next;
   logic                pready_reg;
   logic                pslverr_reg;
   logic                indicator_reg;
   logic                button_reg;

   // Address decode, one hit per bank
   wire                 hit_a      = (PADDR == OFS_BANK_A);
   wire                 hit_c      = (PADDR == OFS_BANK_C);
   wire                 mapped     = hit_a | hit_c;
   wire [1:0]           bank_hit   = {hit_c, hit_a};
   wire                 setup_ph   = PSEL & ~PENABLE;
   wire                 access_end = PSEL & PENABLE & pready_reg;
   wire                 wr_commit  = access_end & PWRITE & ~pslverr_reg;

   assign prdata_reg_unused = 1'b0;
   assign pin_in_all        = {GPIO_C_IN, GPIO_A_IN};

   // Per-bank write merge and drive decode
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b = b + 1) begin : g_bank
         wire bank_wr = wr_commit & bank_hit[b];
         // Byte lanes map one-to-one onto fields
         assign pin_function_select_next[b] = (bank_wr & PSTRB[LANE_MODE]) ?
            PWDATA[FLD_MODE_LSB +: 8] : pin_function_select_reg[b];
         assign pin_direction_next[b] = (bank_wr & PSTRB[LANE_DIR]) ?
            PWDATA[FLD_DIR_LSB +: 8] : pin_direction_reg[b];
         // Bank A has no alternate field: writes dropped
         assign pin_alt_function_next[b] = (bank_wr & PSTRB[LANE_ALT] & BANK_HAS_ALT[b]) ?
            PWDATA[FLD_ALT_LSB +: 8] : pin_alt_function_reg[b];
         assign data_next[b] = (bank_wr & PSTRB[LANE_DATA]) ?
            PWDATA[FLD_DATA_LSB +: 8] : data_reg[b];

         // Plain GPIO output only when mode and alt are clear
         assign pin_drive_en[b*8 +: 8]  = pin_direction_reg[b] &
                                          ~pin_function_select_reg[b] &
                                          ~pin_alt_function_reg[b];
         assign pin_drive_val[b*8 +: 8] = data_reg[b];
      end
   endgenerate

   // Bank A storage
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pin_function_select_reg[0] <= RST_A_MODE;
         pin_direction_reg[0]       <= RST_A_DIR;
         pin_alt_function_reg[0]    <= RST_A_ALT;
         data_reg[0]                <= RST_A_DATA;
      end else begin
         pin_function_select_reg[0] <= pin_function_select_next[0];
         pin_direction_reg[0]       <= pin_direction_next[0];
         pin_alt_function_reg[0]    <= pin_alt_function_next[0];
         data_reg[0]                <= data_next[0];
      end
   end

   // Bank C storage; reset leaves the indicator driven on
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pin_function_select_reg[1] <= RST_C_MODE;
         pin_direction_reg[1]       <= RST_C_DIR;
         pin_alt_function_reg[1]    <= RST_C_ALT;
         data_reg[1]                <= RST_C_DATA;
      end else begin
         pin_function_select_reg[1] <= pin_function_select_next[1];
         pin_direction_reg[1]       <= pin_direction_next[1];
         pin_alt_function_reg[1]    <= pin_alt_function_next[1];
         data_reg[1]                <= data_next[1];
      end
   end

   // Sixteen identical pin cells
   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p = p + 1) begin : g_pin
         bglbp_pin_cell u_cell (
            .clk       (CLK),
            .rst       (RST),
            .pin_in    (pin_in_all[p]),
            .drive_val (pin_drive_val[p]),
            .drive_en  (pin_drive_en[p]),
            .level     (pin_level[p]),
            .pin_out   (pin_out_all[p]),
            .pin_oe    (pin_oe_all[p])
         );
      end
   endgenerate

   assign GPIO_A_OUT = pin_out_all[7:0];
   assign GPIO_A_OE  = pin_oe_all[7:0];
   assign GPIO_C_OUT = pin_out_all[15:8];
   assign GPIO_C_OE  = pin_oe_all[15:8];

   // Read word: data field shows the live pin, not the latch
   assign prdata_next =
      hit_a ? {pin_function_select_reg[0], pin_direction_reg[0],
               8'h00, pin_level[7:0]} :
      hit_c ? {pin_function_select_reg[1], pin_direction_reg[1],
               pin_alt_function_reg[1], pin_level[15:8]} :
              32'h0000_0000;

   // One wait-free access phase; data captured in setup
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setup_ph;
         pslverr_reg <= setup_ph & ~mapped;
         if (setup_ph) begin
            prdata_reg <= PWRITE ? 32'h0000_0000 : prdata_next;
         end
      end
   end

   assign PRDATA  = prdata_reg;
   assign PREADY  = pready_reg;
   assign PSLVERR = pslverr_reg;

   // Board-level view of the indicator and button pins
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         indicator_reg <= 1'b0;
         button_reg    <= 1'b0;
      end else begin
         indicator_reg <= pin_drive_en[8 + PIN_LED] & data_reg[1][PIN_LED];
         button_reg    <= ~pin_level[8 + PIN_BUTTON] &
                          ~pin_drive_en[8 + PIN_BUTTON];
      end
   end

   assign INDICATOR_LIT  = indicator_reg;
   assign BUTTON_PRESSED = button_reg;

endmodule

`default_nettype wire

// >>> testbench/bglbp_checker.sv
// Concurrent checks for the board GPIO block: APB answer timing and board pins.
// Bound to bglbp_top; sees only its ports, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module bglbp_checker (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [7:0]  GPIO_A_OE,
   input wire logic [7:0]  GPIO_C_IN,
   input wire logic [7:0]  GPIO_C_OUT,
   input wire logic [7:0]  GPIO_C_OE,
   input wire logic        INDICATOR_LIT,
   input wire logic        BUTTON_PRESSED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Address decode and write commit as seen from the bus
   wire logic mapped = (PADDR == 12'h000) || (PADDR == 12'h004);
   wire logic commit = PSEL && PENABLE && PREADY && PWRITE;
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   a_ready_setup: assert property (setup_s |=> PREADY)
      else $error("ready missing after setup");
   a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access");
   a_err_unmapped: assert property ((setup_s ##0 !mapped) |=> PSLVERR)
      else $error("no error on unmapped address");
   a_err_mapped: assert property ((setup_s ##0 mapped) |=> !PSLVERR)
      else $error("error on mapped address");
   a_err_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("unmapped read not zero");
   // Drive changes only after a committed write; skip the edge after reset
   // Enables move one edge after the commit edge, so both that edge and the next are exempt
   a_oe_quiet: assert property (!$past(RST) && !commit && !$past(commit)
      |=> $stable(GPIO_C_OE) && $stable(GPIO_A_OE))
      else $error("output enable moved without write");
   // Flag and pin flops load from the same source on the same edge
   a_lit_follows: assert property (INDICATOR_LIT == (GPIO_C_OE[6] && GPIO_C_OUT[6]))
      else $error("indicator flag wrong");
   a_button_press: assert property ($fell(GPIO_C_IN[5]) && !GPIO_C_OE[5] |-> ##[1:4] BUTTON_PRESSED)
      else $error("press not seen");
   a_button_free: assert property ($rose(GPIO_C_IN[5]) |-> ##[1:4] !BUTTON_PRESSED)
      else $error("release not seen");
endmodule
bind bglbp_top bglbp_checker bglbp_checker_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .GPIO_A_OE(GPIO_A_OE), .GPIO_C_IN(GPIO_C_IN), .GPIO_C_OUT(GPIO_C_OUT),
   .GPIO_C_OE(GPIO_C_OE), .INDICATOR_LIT(INDICATOR_LIT), .BUTTON_PRESSED(BUTTON_PRESSED));
`default_nettype wire

// >>> testbench/bglbp_board_model.sv
// Board model: red indicator on bank C pin 6, push button on bank C pin 5.
// Floating lines read the inverse of the drive value so a stale level cannot pass.
`timescale 1ns/1ns
`default_nettype none
module bglbp_board_model (
   input  wire logic       pressed,
   input  wire logic [7:0] c_out,
   input  wire logic [7:0] c_oe,
   output wire logic [7:0] c_in,
   output wire logic       lit
);
   // Driven lines echo, undriven lines invert
   wire logic [7:0] echo = ~(c_oe ^ c_out);
   // Button has a pull-up and shorts low while pressed
   assign c_in = {echo[7:6], ~pressed, echo[4:0]};
   // Active-high indicator
   assign lit = c_oe[6] & c_out[6];
endmodule
`default_nettype wire

// >>> testbench/bglbp_tb_top.sv
// Self-checking bench for the board GPIO block over APB with board model.
// Bank A pins are driven by the bench; bank C faces the board model.
`timescale 1ns/1ns
`default_nettype none
module bglbp_tb_top;
   import bglbp_pkg::*;
   logic        clk, rst, psel, penable, pwrite, button, pready, pslverr, er, lit, ind, btn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [7:0]  a_in, a_out, a_oe, c_in, c_out, c_oe;
   int          err_total, comparisons;
   bglbp_top bglbp_top_i (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .GPIO_A_IN(a_in), .GPIO_A_OUT(a_out),
      .GPIO_A_OE(a_oe), .GPIO_C_IN(c_in), .GPIO_C_OUT(c_out), .GPIO_C_OE(c_oe),
      .INDICATOR_LIT(ind), .BUTTON_PRESSED(btn));
   bglbp_board_model bglbp_board_model_i (.pressed(button), .c_out(c_out), .c_oe(c_oe),
      .c_in(c_in), .lit(lit));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Tests take about a hundred cycles; allow some twenty-five times that
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; request held until ready is seen, answer taken then
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      // Answer is taken at the very edge where ready is seen high
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) err_total++;
   endtask
   // Read-modify-write so untouched pins keep their setup
   task automatic rmw(input logic [11:0] a, input logic [31:0] keep, input logic [31:0] set);
      apb(1'b0, a, 32'h0);
      apb(1'b1, a, (rd & keep) | set);
   endtask
   // Pin levels need three edges to reach the data byte
   task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      repeat (4) @(posedge clk);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      a_in = 8'ha5;
      button = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdchk("bank A reset", OFS_BANK_A, {RST_A_MODE, RST_A_DIR, RST_A_ALT, 8'ha5});
      rdchk("bank C reset", OFS_BANK_C, {RST_C_MODE, RST_C_DIR, RST_C_ALT, 8'hff});
      chk("indicator on", 32'({ind, lit}), 32'h3);
      $display("test reset done");
      a_in <= 8'h5a;
      rmw(OFS_BANK_A, 32'hffffffff, 32'h0000ff00);
      rdchk("bank A alt", OFS_BANK_A, 32'h0000005a);
      chk("bank A oe", 32'(a_oe), 32'h0);
      $display("test bank A done");
      rmw(OFS_BANK_C, 32'hffffffbf, 32'h0);
      rdchk("led off", OFS_BANK_C, 32'h00400020);
      chk("indicator off", 32'({ind, lit}), 32'h0);
      rmw(OFS_BANK_C, 32'hffffffff, 32'h00000040);
      rdchk("led on", OFS_BANK_C, 32'h004000ff);
      chk("indicator back", 32'({ind, lit}), 32'h3);
      $display("test indicator done");
      button <= 1'b1;
      rdchk("pressed", OFS_BANK_C, 32'h004000df);
      chk("press flag", 32'(btn), 32'h1);
      button <= 1'b0;
      rdchk("released", OFS_BANK_C, 32'h004000ff);
      chk("release flag", 32'(btn), 32'h0);
      $display("test button done");
      // Data lane only: mode and direction must survive, pin 6 stays driven
      pstrb <= 4'h1;
      apb(1'b1, OFS_BANK_C, 32'hff0000ff);
      pstrb <= 4'hf;
      rdchk("data lane only", OFS_BANK_C, 32'h00400060);
      chk("lane indicator", 32'({ind, lit}), 32'h3);
      $display("test strobe done");
      apb(1'b1, 12'h008, 32'hffffffff);
      chk("write error", 32'(er), 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk("read error", 32'(er), 32'h1);
      chk("read zero", rd, 32'h0);
      rdchk("no side effect", OFS_BANK_C, 32'h00400060);
      $display("test unmapped done");
      end_of_test();
   end
endmodule
`default_nettype wire
